// *** flr_defines.svh ***
// constants of the fault locator recorder: offsets, fields, reset values, timing
`ifndef FLR_DEFINES_SVH
`define FLR_DEFINES_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define FLR_CLK_HZ          10000000
`define FLR_STAMP_MS        1
`define FLR_STAMP_CYC       ((`FLR_CLK_HZ / 1000) * `FLR_STAMP_MS)
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define FLR_OFS_CTRL        8'h00
`define FLR_OFS_THRESH      8'h04
`define FLR_OFS_XPERKM      8'h08
`define FLR_OFS_BLKSEL      8'h0C
`define FLR_OFS_STAT        8'h10
`define FLR_OFS_MASK        8'h14
`define FLR_OFS_COUNT       8'h18
`define FLR_OFS_HSEL        8'h1C
`define FLR_OFS_HTIME       8'h20
`define FLR_OFS_HINFO       8'h24
`define FLR_OFS_HDIST       8'h28
`define FLR_OFS_HFILL       8'h2C
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define FLR_CTRL_EV_ON      0
`define FLR_CTRL_EV_OFF     1
`define FLR_CTRL_CNT_CLR    2
`define FLR_CTRL_RST        32'h0000_0003
`define FLR_THRESH_RST      16'h000A
`define FLR_XPERKM_RST      16'h007D
`define FLR_ST_REC          0
`define FLR_ST_ON           1
`define FLR_ST_OFF          2
`define FLR_ST_DROP         3
`define FLR_HIST_DEPTH      12
`endif

// *** flr_divider.sv ***
// sequential restoring divider for the fault distance
`timescale 1ns/1ps
module flr_divider #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] dividend_i,
  input  wire logic [W-1:0] divisor_i,
  output logic              done_o,
  output logic [W-1:0]      quot_o
);
  logic [W-1:0]         q_r;
  logic [W:0]           rem_r;
  logic [W-1:0]         div_r;
  logic [$clog2(W+1):0] cnt_r;
  logic                 busy_r;
  wire  [W:0]           shifted = {rem_r[W-1:0], q_r[W-1]};
  wire                  fits    = shifted >= {1'b0, div_r};

  // one quotient bit per cycle; zero divisor gives all ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r    <= '0;
      rem_r  <= '0;
      div_r  <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_o <= 1'b0;
      quot_o <= '0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i && !busy_r) begin
        q_r    <= dividend_i;
        rem_r  <= '0;
        div_r  <= divisor_i;
        cnt_r  <= ($clog2(W+1)+1)'(W);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        rem_r <= fits ? shifted - {1'b0, div_r} : shifted;
        q_r   <= {q_r[W-2:0], fits};
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == 1) begin
          busy_r <= 1'b0;
          done_o <= 1'b1;
          quot_o <= (div_r == '0) ? '1 : {q_r[W-2:0], fits};
        end
      end
    end
  end
endmodule

// *** flr_front_end.sv ***
// front end model: phase measurements, blocking and the trigger level
`timescale 1ns/1ps
module flr_front_end (
  input  wire logic           clk_i,
  output flr_pkg::flr_curr_t  curr_o,
  output flr_pkg::flr_react_t react_o,
  output logic                earth_o,
  output logic                trigger_o,
  output logic [7:0]          block_o,
  output flr_pkg::flr_dir_t   dir_o,
  output logic [2:0]          group_o
);
  // a phase over threshold reads strictly above it
  function automatic logic [15:0] mag(input logic hi, input logic [15:0] t);
    return hi ? 16'(t + 1 + $urandom_range(900, 0)) : 16'($urandom_range(t, 0));
  endfunction
  // new measurement set, held like one 5 ms refresh
  task automatic arm(input logic [2:0] p, input logic e, input logic [7:0] b,
                     input logic [15:0] t);
    @(posedge clk_i);
    curr_o  <= {mag(p[0], t), mag(p[1], t), mag(p[2], t)};
    react_o <= {$urandom, $urandom, $urandom};
    earth_o <= e;
    block_o <= b;
    dir_o   <= flr_pkg::flr_dir_t'(2'($urandom_range(2, 0)));
    group_o <= 3'($urandom);
  endtask
  // trigger level formed by the protection logic
  task automatic level(input logic v);
    @(posedge clk_i);
    trigger_o <= v;
  endtask
  // quiet inputs at time zero
  initial begin
    curr_o    = '0;
    react_o   = '0;
    earth_o   = 1'b0;
    trigger_o = 1'b0;
    block_o   = 8'h00;
    dir_o     = flr_pkg::FLR_DIR_NONE;
    group_o   = 3'h0;
  end
endmodule

// *** flr_pkg.sv ***
// types of the fault locator recorder
package flr_pkg;
  // ----------------------------------------
  // loop codes and direction
  // ----------------------------------------
  typedef enum logic [2:0] {
    FLR_LOOP_AB  = 3'h0,
    FLR_LOOP_BC  = 3'h1,
    FLR_LOOP_CA  = 3'h2,
    FLR_LOOP_AN  = 3'h3,
    FLR_LOOP_BN  = 3'h4,
    FLR_LOOP_CN  = 3'h5,
    FLR_LOOP_ABC = 3'h6
  } flr_loop_t;
  typedef enum logic [1:0] {
    FLR_DIR_NONE = 2'h0,
    FLR_DIR_FWD  = 2'h1,
    FLR_DIR_REV  = 2'h2
  } flr_dir_t;
  // ----------------------------------------
  // measurement sets
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] phase_a_current;
    logic [15:0] phase_b_current;
    logic [15:0] phase_c_current;
  } flr_curr_t;
  typedef struct packed {
    logic [15:0] loop_reactance_ab;
    logic [15:0] loop_reactance_bc;
    logic [15:0] loop_reactance_ca;
    logic [15:0] loop_reactance_a_n;
    logic [15:0] loop_reactance_b_n;
    logic [15:0] loop_reactance_c_n;
  } flr_react_t;
  // one history record
  typedef struct packed {
    logic [31:0] stamp_ms;
    logic        on_event;
    flr_loop_t   loop;
    flr_dir_t    dir;
    logic [2:0]  setting_group;
    logic [15:0] reactance;
    logic [15:0] distance;
  } flr_rec_t;
  // recorder states
  typedef enum logic [1:0] {
    FLR_IDLE = 2'b00,
    FLR_CALC = 2'b01,
    FLR_DONE = 2'b11
  } flr_state_t;
endpackage

// *** flr_recorder.sv ***
// fault locator recorder: trigger check, loop choice, distance and history
//
// Contract
// - uses three phase currents and loop reactances refreshed each 5 ms
// - on trigger, active selected blocking signal suppresses all recording; code still emits the OFF event at the trigger fall
// - without earth voltages only phase-to-phase loops may be recorded
// - loop chosen from currents over threshold at the trigger instant
// - three picks A-B-C on the A-B reactance; A,B picks A-B; B,C picks B-C; A,C picks C-A
// - single phase picks its neutral loop only when earth voltages exist
// - no phase over threshold means no impedance and no record
// - trigger threshold in 0.1 nominal steps, default 1.0
// - line_reactance_per_length held at 0.001 ohm/km, default 0.125
// - rolling history of twelve latest records, oldest dropped
// - every event and record carries a 1 ms time stamp
// - cumulative triggering count, clearable on request
// - ON and OFF events emitted, passed according to a user mask
// - record holds time, event, loop, direction, reactance, distance, group
`timescale 1ns/1ps
`include "flr_defines.svh"
module flr_recorder #(
  parameter int DEPTH     = `FLR_HIST_DEPTH,
  parameter int STAMP_CYC = `FLR_STAMP_CYC,
  parameter int NBLK      = 8
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic [31:0]         wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic                wb_we_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire flr_pkg::flr_curr_t  curr_i,
  input  wire flr_pkg::flr_react_t react_i,
  input  wire logic                earth_volt_ok_i,
  input  wire logic                trigger_i,
  input  wire logic [NBLK-1:0]     block_i,
  input  wire flr_pkg::flr_dir_t   dir_i,
  input  wire logic [2:0]          setting_group_i,
  output logic                     event_valid_o,
  output flr_pkg::flr_rec_t        event_o,
  output logic                     irq_o
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0]          ctrl_r;
  logic [15:0]          thresh_r;
  logic [15:0]          xperkm_r;
  logic [NBLK-1:0]      blksel_r;
  logic [3:0]           stat_r;
  logic [3:0]           mask_r;
  logic [31:0]          count_r;
  logic [3:0]           hsel_r;
  logic [31:0]          ms_r;
  logic [23:0]          tick_r;
  logic                 trig_d_r;
  flr_pkg::flr_rec_t    hist_r [DEPTH];
  logic [3:0]           head_r;
  logic [3:0]           fill_r;
  flr_pkg::flr_state_t  state_r;
  flr_pkg::flr_loop_t   loop_r;
  logic [15:0]          xsel_r;
  logic [31:0]          stamp_r;
  flr_pkg::flr_dir_t    dir_r;
  logic [2:0]           sg_r;
  logic                 div_start_r;

  // ----------------------------------------
  // decode and loop choice
  // ----------------------------------------
  // current compares directly against the raw threshold value, without scaling
  function automatic logic over(input logic [15:0] i, input logic [15:0] t);
    return i > t;
  endfunction
  wire        a_over   = over(curr_i.phase_a_current, thresh_r);
  wire        b_over   = over(curr_i.phase_b_current, thresh_r);
  wire        c_over   = over(curr_i.phase_c_current, thresh_r);
  wire [2:0]  over_v   = {a_over, b_over, c_over};
  wire        blocked  = |(block_i & blksel_r);
  wire        trig_rise = trigger_i && !trig_d_r;
  flr_pkg::flr_loop_t pick_loop;
  logic       pick_ok;
  logic [15:0] pick_x;
  // table of over-threshold combinations to loop
  always_comb begin
    pick_ok   = 1'b1;
    pick_loop = flr_pkg::FLR_LOOP_AB;
    pick_x    = react_i.loop_reactance_ab;
    case (over_v)
      3'b111: pick_loop = flr_pkg::FLR_LOOP_ABC;
      3'b110: pick_loop = flr_pkg::FLR_LOOP_AB;
      3'b011: begin
        pick_loop = flr_pkg::FLR_LOOP_BC;
        pick_x    = react_i.loop_reactance_bc;
      end
      3'b101: begin
        pick_loop = flr_pkg::FLR_LOOP_CA;
        pick_x    = react_i.loop_reactance_ca;
      end
      3'b100: begin
        pick_loop = flr_pkg::FLR_LOOP_AN;
        pick_x    = react_i.loop_reactance_a_n;
        pick_ok   = earth_volt_ok_i;
      end
      3'b010: begin
        pick_loop = flr_pkg::FLR_LOOP_BN;
        pick_x    = react_i.loop_reactance_b_n;
        pick_ok   = earth_volt_ok_i;
      end
      3'b001: begin
        pick_loop = flr_pkg::FLR_LOOP_CN;
        pick_x    = react_i.loop_reactance_c_n;
        pick_ok   = earth_volt_ok_i;
      end
      default: pick_ok = 1'b0;
    endcase
  end
  wire accept = trig_rise && !blocked && pick_ok && state_r == flr_pkg::FLR_IDLE;
  wire trig_fall = !trigger_i && trig_d_r;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  logic        div_done;
  logic [15:0] dist_q;
  flr_divider #(.W(16)) u_div (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .start_i    (div_start_r),
    .dividend_i (xsel_r),
    .divisor_i  (xperkm_r),
    .done_o     (div_done),
    .quot_o     (dist_q)
  );
  // reactance in 0.001 ohm over ohm/km in 0.001 gives whole km

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire        wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        wb_wr   = wb_req && wb_we_i;
  wire [7:0]  wb_ofs  = wb_adr_i[7:0];
  wire [3:0]  hidx_w  = (hsel_r < 4'(DEPTH)) ? hsel_r : 4'h0;
  // five bits so head plus depth cannot wrap before the modulo
  wire [4:0]  rd_sum  = 5'(head_r) + 5'(DEPTH) - 5'h01 - 5'(hidx_w);
  wire [3:0]  rd_pos  = 4'(rd_sum % 5'(DEPTH));
  wire flr_pkg::flr_rec_t hrec = hist_r[rd_pos];
  wire        cnt_clr = wb_wr && wb_ofs == `FLR_OFS_CTRL && wb_sel_i[0]
                        && wb_dat_i[`FLR_CTRL_CNT_CLR];
  wire [31:0] stat_clr = (wb_wr && wb_ofs == `FLR_OFS_STAT && wb_sel_i[0])
                         ? wb_dat_i : 32'h0;
  wire        ev_on   = div_done && ctrl_r[`FLR_CTRL_EV_ON];
  wire        ev_off  = trig_fall && ctrl_r[`FLR_CTRL_EV_OFF];
  wire        drop    = trig_rise && state_r == flr_pkg::FLR_IDLE && !accept;
  logic [31:0] rd_data;
  // read mux; unmapped offsets read zero
  always_comb begin
    case (wb_ofs)
      `FLR_OFS_CTRL:   rd_data = {29'h0, ctrl_r[2:0] & 3'h3};
      `FLR_OFS_THRESH: rd_data = {16'h0, thresh_r};
      `FLR_OFS_XPERKM: rd_data = {16'h0, xperkm_r};
      `FLR_OFS_BLKSEL: rd_data = 32'(blksel_r);
      `FLR_OFS_STAT:   rd_data = {28'h0, stat_r};
      `FLR_OFS_MASK:   rd_data = {28'h0, mask_r};
      `FLR_OFS_COUNT:  rd_data = count_r;
      `FLR_OFS_HSEL:   rd_data = {28'h0, hsel_r};
      `FLR_OFS_HTIME:  rd_data = hrec.stamp_ms;
      `FLR_OFS_HINFO:  rd_data = {7'h0, hrec.setting_group, hrec.dir, hrec.loop,
                                  hrec.on_event, hrec.reactance};
      `FLR_OFS_HDIST:  rd_data = {16'h0, hrec.distance};
      `FLR_OFS_HFILL:  rd_data = {28'h0, fill_r};
      default:         rd_data = 32'h0;
    endcase
  end
  assign irq_o = |(stat_r & mask_r);

  // ----------------------------------------
  // bus slave: one-cycle ack
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= rd_data;
    end
  end

  // ----------------------------------------
  // writable settings
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r   <= `FLR_CTRL_RST;
      thresh_r <= `FLR_THRESH_RST;
      xperkm_r <= `FLR_XPERKM_RST;
      blksel_r <= '0;
      mask_r   <= 4'h0;
      hsel_r   <= 4'h0;
    end else if (ce_i && wb_wr) begin
      case (wb_ofs)
        `FLR_OFS_CTRL:   if (wb_sel_i[0]) ctrl_r[1:0] <= wb_dat_i[1:0];
        `FLR_OFS_THRESH: if (wb_sel_i[0]) thresh_r <= wb_dat_i[15:0];
        `FLR_OFS_XPERKM: if (wb_sel_i[0]) xperkm_r <= wb_dat_i[15:0];
        `FLR_OFS_BLKSEL: if (wb_sel_i[0]) blksel_r <= wb_dat_i[NBLK-1:0];
        `FLR_OFS_MASK:   if (wb_sel_i[0]) mask_r <= wb_dat_i[3:0];
        `FLR_OFS_HSEL:   if (wb_sel_i[0]) hsel_r <= wb_dat_i[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // millisecond time base
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_r <= 24'h0;
      ms_r   <= 32'h0;
    end else if (ce_i) begin
      if (tick_r == 24'(STAMP_CYC - 1)) begin
        tick_r <= 24'h0;
        ms_r   <= ms_r + 32'h1;
      end else begin
        tick_r <= tick_r + 24'h1;
      end
    end
  end

  // ----------------------------------------
  // status flags: set wins over write-one clear
  // ----------------------------------------
  wire [3:0] stat_set = {drop, ev_off, ev_on, div_done};
  always_ff @(posedge clk_i) begin
    if (rst_i) stat_r <= 4'h0;
    else if (ce_i) stat_r <= (stat_r & ~stat_clr[3:0]) | stat_set;
  end

  // ----------------------------------------
  // trigger capture and sequencing
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_d_r    <= 1'b0;
      state_r     <= flr_pkg::FLR_IDLE;
      loop_r      <= flr_pkg::FLR_LOOP_AB;
      xsel_r      <= 16'h0;
      stamp_r     <= 32'h0;
      dir_r       <= flr_pkg::FLR_DIR_NONE;
      sg_r        <= 3'h0;
      div_start_r <= 1'b0;
    end else if (ce_i) begin
      trig_d_r    <= trigger_i;
      div_start_r <= 1'b0;
      case (state_r)
        flr_pkg::FLR_IDLE: if (accept) begin
          loop_r  <= pick_loop;
          xsel_r  <= pick_x;
          stamp_r <= ms_r;
          dir_r   <= dir_i;
          sg_r    <= setting_group_i;
          div_start_r <= 1'b1;
          state_r <= flr_pkg::FLR_CALC;
        end
        flr_pkg::FLR_CALC: if (div_done) state_r <= flr_pkg::FLR_DONE;
        flr_pkg::FLR_DONE: state_r <= flr_pkg::FLR_IDLE;
        default: state_r <= flr_pkg::FLR_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // history ring, counter and event output
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_r        <= 4'h0;
      fill_r        <= 4'h0;
      count_r       <= 32'h0;
      event_valid_o <= 1'b0;
      event_o       <= '0;
      for (int i = 0; i < DEPTH; i++) hist_r[i] <= '0;
    end else if (ce_i) begin
      event_valid_o <= ev_on || ev_off;
      if (div_done) begin
        hist_r[head_r] <= {stamp_r, 1'b1, loop_r, dir_r, sg_r, xsel_r, dist_q};
        head_r <= (head_r == 4'(DEPTH - 1)) ? 4'h0 : head_r + 4'h1;
        if (fill_r != 4'(DEPTH)) fill_r <= fill_r + 4'h1;
      end
      if (ev_on)
        event_o <= {stamp_r, 1'b1, loop_r, dir_r, sg_r, xsel_r, dist_q};
      else if (ev_off)
        event_o <= {ms_r, 1'b0, loop_r, dir_r, sg_r, xsel_r, 16'h0};
      if (div_done) count_r <= count_r + 32'h1;
      else if (cnt_clr) count_r <= 32'h0;
    end
  end
endmodule

// *** flr_recorder_properties.sv ***
// port assertions of the fault locator recorder
`timescale 1ns/1ps
module flr_recorder_properties (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic              earth_volt_ok_i,
  input wire logic              trigger_i,
  input wire flr_pkg::flr_dir_t dir_i,
  input wire logic [2:0]        setting_group_i,
  input wire logic              event_valid_o,
  input wire flr_pkg::flr_rec_t event_o
);
  logic        trig_r;
  logic [7:0]  rise_r;
  logic [7:0]  fall_r;
  logic [7:0]  rise_nxt;
  logic [7:0]  fall_nxt;
  logic [31:0] stamp_r;
  // saturating cycle counts since the last trigger edges
  assign rise_nxt = (trigger_i && !trig_r) ? 8'h00 : rise_r + {7'h00, rise_r != 8'hFF};
  assign fall_nxt = (!trigger_i && trig_r) ? 8'h00 : fall_r + {7'h00, fall_r != 8'hFF};
  // edge history and last event stamp
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_r  <= 1'b0;
      rise_r  <= 8'hFF;
      fall_r  <= 8'hFF;
      stamp_r <= 32'h0;
    end else if (ce_i) begin
      trig_r  <= trigger_i;
      rise_r  <= rise_nxt;
      fall_r  <= fall_nxt;
      stamp_r <= event_valid_o ? event_o.stamp_ms : stamp_r;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_on_timing: assert property (event_valid_o && event_o.on_event |-> rise_r <= 8'h1E)
    else $error("on event not after a trigger rise");
  chk_off_timing: assert property (event_valid_o && !event_o.on_event |-> fall_r <= 8'h03)
    else $error("off event not after a trigger fall");
  chk_stamp_order: assert property (event_valid_o |-> event_o.stamp_ms >= stamp_r)
    else $error("event stamp went backwards");
  chk_pp_loop: assert property (event_valid_o && event_o.on_event && !earth_volt_ok_i
    |-> !(event_o.loop inside {flr_pkg::FLR_LOOP_AN, flr_pkg::FLR_LOOP_BN, flr_pkg::FLR_LOOP_CN}))
    else $error("neutral loop without earth voltages");
  chk_rec_fields: assert property (event_valid_o && event_o.on_event
    |-> event_o.dir == dir_i && event_o.setting_group == setting_group_i)
    else $error("record direction or group wrong");
endmodule
bind flr_recorder flr_recorder_properties u_flr_recorder_properties (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .earth_volt_ok_i(earth_volt_ok_i), .trigger_i(trigger_i),
  .dir_i(dir_i), .setting_group_i(setting_group_i), .event_valid_o(event_valid_o),
  .event_o(event_o));

// *** tb.sv ***
// self-checking bench of the fault locator recorder
`timescale 1ns/1ps
`include "flr_defines.svh"
module tb;
  logic                clk_i;
  logic                rst_i;
  logic                ce_i;
  logic [31:0]         wb_adr_i;
  logic [31:0]         wb_dat_i;
  logic [31:0]         wb_dat_o;
  logic [3:0]          wb_sel_i;
  logic                wb_we_i;
  logic                wb_cyc_i;
  logic                wb_stb_i;
  logic                wb_ack_o;
  logic                event_valid_o;
  logic                irq_o;
  logic                earth;
  logic                trigger;
  logic [7:0]          blk;
  logic [7:0]          blksel;
  logic [2:0]          grp;
  logic [15:0]         perkm;
  logic [15:0]         thr;
  logic [35:0]         last_x;
  logic [35:0]         ev_x;
  flr_pkg::flr_curr_t  curr;
  flr_pkg::flr_react_t react;
  flr_pkg::flr_dir_t   dir;
  flr_pkg::flr_rec_t   event_o;
  logic [31:0]         rd_q[$];
  logic [35:0]         ev_q[$];
  int                  errors;
  int                  tests_run;
  flr_recorder #(.STAMP_CYC(10)) u_flr_recorder (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .curr_i(curr), .react_i(react),
    .earth_volt_ok_i(earth), .trigger_i(trigger), .block_i(blk), .dir_i(dir),
    .setting_group_i(grp), .event_valid_o(event_valid_o), .event_o(event_o), .irq_o(irq_o));
  flr_front_end u_flr_front_end (.clk_i(clk_i), .curr_o(curr), .react_o(react),
    .earth_o(earth), .trigger_o(trigger), .block_o(blk), .dir_o(dir), .group_o(grp));
  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_event(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // classic single cycle, held until ack is sampled
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) check_word(32'hX, d);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wb_rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb_io(1'b0, a, 32'h0);
  endtask
  // expected record: {on, loop, reactance, distance}, all ones when none
  function automatic logic [35:0] expect_rec(input logic [2:0] p, input logic e);
    logic [18:0] lr;
    case (p)
      3'h7:    lr = {flr_pkg::FLR_LOOP_ABC, react.loop_reactance_ab};
      3'h3:    lr = {flr_pkg::FLR_LOOP_AB, react.loop_reactance_ab};
      3'h6:    lr = {flr_pkg::FLR_LOOP_BC, react.loop_reactance_bc};
      3'h5:    lr = {flr_pkg::FLR_LOOP_CA, react.loop_reactance_ca};
      3'h1:    lr = {flr_pkg::FLR_LOOP_AN, react.loop_reactance_a_n};
      3'h2:    lr = {flr_pkg::FLR_LOOP_BN, react.loop_reactance_b_n};
      3'h4:    lr = {flr_pkg::FLR_LOOP_CN, react.loop_reactance_c_n};
      default: lr = '1;
    endcase
    if (lr === '1 || (!e && p inside {3'h1, 3'h2, 3'h4})) return '1;
    return {1'b1, lr, lr[15:0] / perkm};
  endfunction
  // one trigger: note the results, pulse the level, wait for the notes to drain
  task automatic fire(input logic [2:0] p, input logic e, input logic [7:0] b,
                      input logic off);
    int n;
    u_flr_front_end.arm(p, e, b, thr);
    @(posedge clk_i);
    last_x = expect_rec(p, e);
    if (last_x !== '1 && (b & blksel) == 8'h00) ev_q.push_back(last_x);
    if (off) ev_q.push_back(36'h7_FFFF_FFFF);
    u_flr_front_end.level(1'b1);
    repeat (24) @(posedge clk_i);
    u_flr_front_end.level(1'b0);
    n = 0;
    while (ev_q.size() != 0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (ev_q.size() != 0) check_event(36'hX, ev_q.pop_front());
    ev_q.delete();
    repeat (4) @(posedge clk_i);
  endtask
  // oldest note against each result that appears
  always @(posedge clk_i) begin
    if (wb_ack_o && !wb_we_i) check_word(wb_dat_o, rd_q.size() ? rd_q.pop_front() : 32'hX);
    if (event_valid_o) begin
      ev_x = ev_q.size() ? ev_q.pop_front() : 36'hX;
      check_event({event_o.on_event, ev_x[35] ? {event_o.loop, event_o.reactance,
                   event_o.distance} : ev_x[34:0]}, ev_x);
    end
  end
  // hang guard
  initial begin
    #(100 * 20000);
    errors++;
    conclude();
  end
  // main sequence
  initial begin
    errors = 0;
    tests_run = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'hF;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    thr = 16'h000A;
    blksel = 8'h00;
    void'($urandom(94482));
    perkm = 16'($urandom_range(1000, 1));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_rd(`FLR_OFS_CTRL, 32'h3);
    wb_rd(`FLR_OFS_THRESH, 32'hA);
    wb_rd(`FLR_OFS_XPERKM, 32'h7D);
    wb_rd(8'h40, 32'h0);
    $display("test defaults done");
    wb_io(1'b1, `FLR_OFS_XPERKM, {16'h0, perkm});
    fire(3'h3, 1'b1, 8'h00, 1'b1);
    $display("test on off events done");
    thr = 16'($urandom_range(50, 5));
    wb_io(1'b1, `FLR_OFS_THRESH, {16'h0, thr});
    wb_io(1'b1, `FLR_OFS_CTRL, 32'h1);
    for (int i = 0; i < 16; i++) fire(i[2:0], i[3], 8'h00, 1'b0);
    $display("test loop table done");
    wb_io(1'b1, `FLR_OFS_STAT, 32'hF);
    blksel = 8'h10;
    wb_io(1'b1, `FLR_OFS_BLKSEL, 32'h10);
    fire(3'h7, 1'b1, 8'hFF, 1'b0);
    fire(3'h3, 1'b0, 8'hEF, 1'b0);
    wb_rd(`FLR_OFS_STAT, 32'hB);
    wb_io(1'b1, `FLR_OFS_MASK, 32'h8);
    check_word({31'h0, irq_o}, 32'h1);
    wb_io(1'b1, `FLR_OFS_STAT, 32'h8);
    check_word({31'h0, irq_o}, 32'h0);
    wb_rd(`FLR_OFS_STAT, 32'h3);
    // a write without byte lane zero must leave the mask alone
    wb_sel_i <= 4'hE;
    wb_io(1'b1, `FLR_OFS_MASK, 32'hF);
    wb_sel_i <= 4'hF;
    wb_rd(`FLR_OFS_MASK, 32'h8);
    $display("test blocking and interrupt done");
    wb_rd(`FLR_OFS_COUNT, 32'hD);
    wb_rd(`FLR_OFS_HFILL, 32'hC);
    wb_io(1'b1, `FLR_OFS_HSEL, 32'h0);
    wb_rd(`FLR_OFS_HDIST, {16'h0, last_x[15:0]});
    wb_rd(`FLR_OFS_HINFO, {7'h0, grp, dir, last_x[34:32], 1'b1, last_x[31:16]});
    wb_io(1'b1, `FLR_OFS_CTRL, 32'h5);
    wb_rd(`FLR_OFS_COUNT, 32'h0);
    $display("test history and counter done");
    // a trigger pulse while the clock enable is low must leave no trace
    ce_i <= 1'b0;
    u_flr_front_end.level(1'b1);
    repeat (30) @(posedge clk_i);
    u_flr_front_end.level(1'b0);
    @(posedge clk_i);
    ce_i <= 1'b1;
    wb_rd(`FLR_OFS_COUNT, 32'h0);
    $display("test clock enable done");
    conclude();
  end
endmodule
